// >>> design/rdmsc_pkg.sv
package rdmsc_pkg;

    typedef enum logic [1:0] {
        RDMSC_MODE_GFSK,
        RDMSC_MODE_BYTE,
        RDMSC_MODE_TWO,
        RDMSC_MODE_ONE
    } rdmsc_mode_t;

    localparam int BYTE_W        = 8;
    localparam int FIFO_DEPTH    = 4;
    localparam int CLK_MHZ       = 200;
    localparam int GFSK_RATE_MHZ = 1;
    // Clock cycles per GFSK bit at 1 Mbps
    localparam int GFSK_BIT_CYC  = CLK_MHZ / GFSK_RATE_MHZ;
    localparam int CHIPS_LONG    = 64;
    localparam int CHIPS_SHORT   = 32;
    localparam logic [15:0] CRC_POLY = 16'h1021;
    localparam logic [15:0] CRC_INIT = 16'hFFFF;
    localparam logic [7:0]  ACK_BYTE = 8'hA5;
    localparam logic [1:0]  CRC_BYTES = 2'h2;

    typedef struct packed {
        logic [7:0] data;
        logic       last;
    } rdmsc_byte_t;

    typedef struct packed {
        rdmsc_mode_t mode;
        logic        short_code;
    } rdmsc_cfg_t;

    // One transmitted symbol: GFSK bit or spread symbol value
    typedef struct packed {
        logic       gfsk;
        logic [7:0] value;
        logic       short_code;
        logic       crc;
    } rdmsc_sym_t;

endpackage

// >>> design/rdmsc_fifo.sv
`timescale 1ns/1ps
module rdmsc_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 4
) (
    input  wire logic             I_CLK,   // Clock
    input  wire logic             I_RSTN,  // Sync reset, active low
    input  wire logic [WIDTH-1:0] i_data,  // Write data
    input  wire logic             i_valid, // Write valid
    output logic                  o_ready, // Not full
    output logic [WIDTH-1:0]      o_data,  // Head data
    output logic                  o_valid, // Not empty
    input  wire logic             i_ready  // Read accept
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0]   cnt;
    } rdmsc_fifo_st_t;

    rdmsc_fifo_st_t   st_r;
    rdmsc_fifo_st_t   st_nxt;
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic             wr;
    logic             rd;

    assign o_ready = (st_r.cnt != (AW+1)'(DEPTH));
    assign o_valid = (st_r.cnt != '0);
    assign wr      = i_valid && o_ready;
    assign rd      = o_valid && i_ready;
    assign o_data  = mem_r[st_r.rp];

    always_comb
    begin
        st_nxt = st_r;
        if (wr)
        begin
            st_nxt.wp = st_r.wp + 1'b1;
        end
        if (rd)
        begin
            st_nxt.rp = st_r.rp + 1'b1;
        end
        st_nxt.cnt = st_r.cnt + (AW+1)'(wr) - (AW+1)'(rd);
    end

    always_ff @(posedge I_CLK)
    begin
        if (!I_RSTN)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
        if (wr)
        begin
            mem_r[st_r.wp] <= i_data;
        end
    end
endmodule

// >>> design/rdmsc_crc.sv
`timescale 1ns/1ps
module rdmsc_crc (
    input  wire logic [15:0] i_crc,  // Running CRC
    input  wire logic [7:0]  i_byte, // Byte to fold in
    output logic [15:0]      o_crc   // Updated CRC
);
    logic [15:0] c [9];

    assign c[0] = i_crc;
    genvar g;
    generate
        for (g = 0; g < 8; g++)
        begin : g_bit
            logic fb;
            assign fb     = c[g][15] ^ i_byte[7-g];
            assign c[g+1] = {c[g][14:0], 1'b0} ^ (fb ? rdmsc_pkg::CRC_POLY : 16'h0000);
        end
    endgenerate
    assign o_crc = c[8];
endmodule

// >>> design/rdmsc_top.sv
// Function
// - GFSK mode sends unspread data at one megabit per second.
// - Byte-per-symbol mode maps one full byte onto each PN symbol.
// - Two-bit mode maps exactly two data bits onto each PN symbol.
// - One-bit mode maps exactly one data bit onto each PN symbol.
// - Spread modes support 64-chip and 32-chip data PN codes.
// - Data mode codes only what follows the start-of-packet marker.
// - Length, payload and CRC of a packet share one data mode.
// - Symbol mapping for DSSS, chips made outside; CRC16 in every mode, frame end taken from I_RX_LAST.
// - Framed receive takes GFSK, 64-chip byte and 32-chip two-bit symbols, no preselect.
// - Optionally send an acknowledge packet after a valid reception; good frames that end while one is pending share it.
`timescale 1ns/1ps
module rdmsc_top (
    input  wire logic                    I_CLK,          // 200 MHz clock
    input  wire logic                    I_RSTN,         // Sync reset, active low
    input  wire rdmsc_pkg::rdmsc_cfg_t   I_CFG,          // Mode and PN length
    input  wire logic                    I_AUTO_ACK,     // Enable auto acknowledge
    input  wire rdmsc_pkg::rdmsc_byte_t  I_TX_BYTE,      // Length/payload byte
    input  wire logic                    I_TX_VALID,     // Byte valid
    output logic                         O_TX_READY,     // FIFO can take byte
    input  wire logic                    I_SOP_DONE,     // Marker sent, data may start
    output logic                         O_SYM_VALID,    // Symbol presented
    output rdmsc_pkg::rdmsc_sym_t        O_SYM,          // Symbol to modulator
    input  wire logic                    I_SYM_READY,    // Modulator takes symbol
    output logic                         O_BUSY,         // Packet in progress
    input  wire logic                    I_RX_SYM_VALID, // Received symbol
    input  wire rdmsc_pkg::rdmsc_sym_t   I_RX_SYM,       // Despread symbol, mode tagged
    input  wire logic                    I_RX_LAST,      // End of frame detected
    output logic                         O_RX_VALID,     // Received byte pulse
    output logic [7:0]                   O_RX_BYTE,      // Received byte
    output logic                         O_RX_DONE,      // Frame end pulse
    output logic                         O_RX_CRC_OK     // CRC good at frame end
);
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_WAIT_SOP,
        ST_DATA,
        ST_CRC,
        ST_ACK
    } rdmsc_state_t;

    typedef struct packed {
        rdmsc_state_t          state;
        rdmsc_pkg::rdmsc_cfg_t cfg;
        logic [7:0]            sh;
        logic [3:0]            left;
        logic                  last;
        logic [15:0]           crc;
        logic [1:0]            crc_idx;
        logic [7:0]            pace;
        logic                  sym_v;
        rdmsc_pkg::rdmsc_sym_t sym;
        logic [15:0]           rcrc;
        logic [7:0]            rsh;
        logic [3:0]            rcnt;
        logic                  rx_v;
        logic [7:0]            rx_b;
        logic                  rx_done;
        logic                  rx_ok;
        logic                  ack_pend;
    } rdmsc_st_t;

    rdmsc_st_t              st_r;
    rdmsc_st_t              st_nxt;
    rdmsc_pkg::rdmsc_byte_t f_data;
    logic                   f_valid;
    logic                   f_ready;
    logic [15:0]            tx_crc_nxt;
    logic [15:0]            rx_crc_nxt;
    logic [3:0]             bits_per_sym;
    logic [3:0]             rx_bits;
    logic [7:0]             rx_asm;
    logic                   sym_take;
    logic                   rx_byte_done;

    rdmsc_fifo #(
        .WIDTH ($bits(rdmsc_pkg::rdmsc_byte_t)),
        .DEPTH (rdmsc_pkg::FIFO_DEPTH)
    ) u_fifo (
        .I_CLK   (I_CLK),
        .I_RSTN  (I_RSTN),
        .i_data  (I_TX_BYTE),
        .i_valid (I_TX_VALID),
        .o_ready (O_TX_READY),
        .o_data  (f_data),
        .o_valid (f_valid),
        .i_ready (f_ready)
    );

    // Transmit CRC folds in each length/payload byte as it is loaded
    rdmsc_crc u_tx_crc (
        .i_crc  (st_r.crc),
        .i_byte (f_data.data),
        .o_crc  (tx_crc_nxt)
    );

    // Receive CRC folds every byte, CRC included; zero residual is good
    rdmsc_crc u_rx_crc (
        .i_crc  (st_r.rcrc),
        .i_byte (rx_asm),
        .o_crc  (rx_crc_nxt)
    );

    // Data bits carried by one transmitted symbol
    always_comb
    begin
        unique case (st_r.cfg.mode)
            rdmsc_pkg::RDMSC_MODE_GFSK: bits_per_sym = 4'h1;
            rdmsc_pkg::RDMSC_MODE_BYTE: bits_per_sym = 4'h8;
            rdmsc_pkg::RDMSC_MODE_TWO:  bits_per_sym = 4'h2;
            rdmsc_pkg::RDMSC_MODE_ONE:  bits_per_sym = 4'h1;
        endcase
    end

    // Receive width follows the tags on each symbol, no rate preselect.
    // CRC symbols keep the width of the frame they close.
    always_comb
    begin
        rx_asm = st_r.rsh;
        unique case ({I_RX_SYM.gfsk, I_RX_SYM.short_code})
            2'h0:    rx_bits = 4'h8;
            2'h1:    rx_bits = 4'h2;
            default: rx_bits = 4'h1;
        endcase
        if (rx_bits == 4'h8)
        begin
            rx_asm = I_RX_SYM.value;
        end
        else if (rx_bits == 4'h2)
        begin
            rx_asm = {st_r.rsh[5:0], I_RX_SYM.value[1:0]};
        end
        else
        begin
            rx_asm = {st_r.rsh[6:0], I_RX_SYM.value[0]};
        end
    end

    assign f_ready     = (st_r.state == ST_DATA) && (st_r.left == 4'h0) && !st_r.sym_v
                         && !st_r.last;
    assign O_SYM_VALID = st_r.sym_v && (st_r.pace == 8'h00);
    assign sym_take    = O_SYM_VALID && I_SYM_READY;
    // Widened so a stray tag mix cannot wrap the bit count
    assign rx_byte_done = ({1'b0, st_r.rcnt} + {1'b0, rx_bits}) >= 5'h08;
    assign O_SYM       = st_r.sym;
    assign O_BUSY      = (st_r.state != ST_IDLE);
    assign O_RX_VALID  = st_r.rx_v;
    assign O_RX_BYTE   = st_r.rx_b;
    assign O_RX_DONE   = st_r.rx_done;
    assign O_RX_CRC_OK = st_r.rx_ok;

    always_comb
    begin
        st_nxt         = st_r;
        st_nxt.rx_v    = 1'b0;
        st_nxt.rx_done = 1'b0;
        if (st_r.pace != 8'h00)
        begin
            st_nxt.pace = st_r.pace - 8'h01;
        end
        // Symbol taken by modulator; unspread bits then wait one bit time
        if (sym_take)
        begin
            st_nxt.sym_v = 1'b0;
            if (st_r.cfg.mode == rdmsc_pkg::RDMSC_MODE_GFSK)
            begin
                st_nxt.pace = 8'(rdmsc_pkg::GFSK_BIT_CYC - 1);
            end
        end
        unique case (st_r.state)
            ST_IDLE:
            begin
                if (st_r.ack_pend)
                begin
                    // Acknowledge also goes out behind its own marker
                    st_nxt.ack_pend = 1'b0;
                    st_nxt.state    = ST_WAIT_SOP;
                    st_nxt.cfg      = I_CFG;
                    st_nxt.sh       = rdmsc_pkg::ACK_BYTE;
                    st_nxt.left     = 4'h0;
                    st_nxt.last     = 1'b1;
                end
                else if (f_valid)
                begin
                    st_nxt.cfg   = I_CFG;
                    st_nxt.crc   = rdmsc_pkg::CRC_INIT;
                    st_nxt.state = ST_WAIT_SOP;
                    st_nxt.last  = 1'b0;
                end
            end

            ST_WAIT_SOP:
            begin
                // Last set here marks a pending acknowledge, not a data byte
                if (I_SOP_DONE)
                begin
                    st_nxt.state = st_r.last ? ST_ACK : ST_DATA;
                    st_nxt.left  = st_r.last ? 4'h8 : 4'h0;
                    st_nxt.last  = 1'b0;
                end
            end

            ST_DATA, ST_CRC, ST_ACK:
            begin
                if (!st_r.sym_v && st_nxt.sym_v == 1'b0 && st_r.left != 4'h0)
                begin
                    // Emit next symbol of current byte in latched mode
                    st_nxt.sym_v            = 1'b1;
                    st_nxt.sym.gfsk         = (st_r.cfg.mode == rdmsc_pkg::RDMSC_MODE_GFSK);
                    st_nxt.sym.short_code   = st_r.cfg.short_code;
                    st_nxt.sym.crc          = (st_r.state == ST_CRC);
                    if (bits_per_sym == 4'h8)
                    begin
                        st_nxt.sym.value = st_r.sh;
                        st_nxt.left      = 4'h0;
                    end
                    else if (bits_per_sym == 4'h2)
                    begin
                        st_nxt.sym.value = {6'h00, st_r.sh[7:6]};
                        st_nxt.sh        = {st_r.sh[5:0], 2'b00};
                        st_nxt.left      = st_r.left - 4'h2;
                    end
                    else
                    begin
                        st_nxt.sym.value = {7'h00, st_r.sh[7]};
                        st_nxt.sh        = {st_r.sh[6:0], 1'b0};
                        st_nxt.left      = st_r.left - 4'h1;
                    end
                end
                else if (!st_r.sym_v && st_r.left == 4'h0)
                begin
                    if (st_r.state == ST_DATA && !st_r.last && f_valid)
                    begin
                        st_nxt.sh   = f_data.data;
                        st_nxt.left = 4'h8;
                        st_nxt.last = f_data.last;
                        st_nxt.crc  = tx_crc_nxt;
                    end
                    // CRC goes out high byte first, in the packet's own mode
                    else if (st_r.state == ST_DATA && st_r.last)
                    begin
                        st_nxt.state   = ST_CRC;
                        st_nxt.sh      = st_r.crc[15:8];
                        st_nxt.left    = 4'h8;
                        st_nxt.crc_idx = 2'h1;
                    end
                    else if (st_r.state == ST_CRC && st_r.crc_idx != rdmsc_pkg::CRC_BYTES)
                    begin
                        st_nxt.sh      = st_r.crc[7:0];
                        st_nxt.left    = 4'h8;
                        st_nxt.crc_idx = st_r.crc_idx + 2'h1;
                    end
                    // Leave only after the final unspread bit time has run out
                    else if (st_r.state != ST_DATA && st_r.pace == 8'h00)
                    begin
                        st_nxt.state = ST_IDLE;
                    end
                end
            end

            // Unused state codes fall back to idle
            default:
            begin
                st_nxt.state = ST_IDLE;
            end
        endcase

        // Receive side: assemble bytes, fold CRC, flag frame end
        if (I_RX_SYM_VALID)
        begin
            st_nxt.rsh  = rx_asm;
            st_nxt.rcnt = st_r.rcnt + rx_bits;
            if (rx_byte_done)
            begin
                st_nxt.rcnt = 4'h0;
                st_nxt.rcrc = rx_crc_nxt;
                st_nxt.rx_v = !I_RX_SYM.crc;
                st_nxt.rx_b = rx_asm;
            end
        end
        if (I_RX_LAST)
        begin
            st_nxt.rx_done  = 1'b1;
            st_nxt.rx_ok    = (st_nxt.rcrc == 16'h0000);
            st_nxt.rcrc     = rdmsc_pkg::CRC_INIT;
            st_nxt.rcnt     = 4'h0;
            // A new good frame adds to, never cancels, a pending acknowledge
            st_nxt.ack_pend = st_nxt.ack_pend || (I_AUTO_ACK && st_nxt.rx_ok);
        end
    end

    always_ff @(posedge I_CLK)
    begin
        if (!I_RSTN)
        begin
            st_r       <= '0;
            st_r.state <= ST_IDLE;
            // Receive CRC starts from its seed
            st_r.rcrc  <= rdmsc_pkg::CRC_INIT;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end
endmodule

// >>> testbench/rdmsc_assertions.sv
`timescale 1ns/1ps
module rdmsc_assertions (
    input wire logic                  I_CLK,       // Clock
    input wire logic                  I_RSTN,      // Sync reset, active low
    input wire rdmsc_pkg::rdmsc_cfg_t I_CFG,       // Mode and code length
    input wire logic                  I_AUTO_ACK,  // Ack enable
    input wire logic                  I_SOP_DONE,  // Marker sent
    input wire logic                  O_SYM_VALID, // Symbol offered
    input wire rdmsc_pkg::rdmsc_sym_t O_SYM,       // Offered symbol
    input wire logic                  I_SYM_READY, // Symbol taken
    input wire logic                  O_BUSY,      // Packet in progress
    input wire logic                  O_RX_DONE,   // Frame end pulse
    input wire logic                  O_RX_CRC_OK  // CRC good
);
    rdmsc_pkg::rdmsc_cfg_t cfg_r;
    logic [8:0]            gap_r;
    logic                  had_r;
    logic                  mark_r;
    wire                   take = O_SYM_VALID && I_SYM_READY;
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RSTN);
    // Follows the setting while idle, frozen while a packet runs
    always_ff @(posedge I_CLK)
    begin
        if (!O_BUSY) cfg_r <= I_CFG;
        gap_r <= take ? 9'h000 : (gap_r == 9'h1FF ? gap_r : gap_r + 9'h001);
        had_r <= I_RSTN && O_BUSY && (had_r || take);
        mark_r <= I_RSTN && O_BUSY && (mark_r || I_SOP_DONE);
    end
    a_sym_holds: assert property (O_SYM_VALID && !I_SYM_READY |=> O_SYM_VALID && $stable(O_SYM))
        else $error("symbol changed before it was taken");
    a_gfsk_rate: assert property (take && O_SYM.gfsk && had_r |-> gap_r >= 9'(rdmsc_pkg::GFSK_BIT_CYC - 1))
        else $error("unspread bits closer than one bit time");
    a_mode_tags: assert property (O_SYM_VALID |-> O_SYM.gfsk == (cfg_r.mode == rdmsc_pkg::RDMSC_MODE_GFSK) && O_SYM.short_code == cfg_r.short_code)
        else $error("symbol tags differ from packet setting");
    a_two_bits: assert property (O_SYM_VALID && cfg_r.mode == rdmsc_pkg::RDMSC_MODE_TWO |-> O_SYM.value[7:2] == 6'h00)
        else $error("two-bit symbol wider than two bits");
    a_one_bit: assert property (O_SYM_VALID && cfg_r.mode == rdmsc_pkg::RDMSC_MODE_ONE |-> O_SYM.value[7:1] == 7'h00)
        else $error("one-bit symbol wider than one bit");
    a_idle_quiet: assert property (!O_BUSY |-> !O_SYM_VALID)
        else $error("symbol offered outside a packet");
    a_marker_first: assert property (O_SYM_VALID |-> mark_r)
        else $error("data symbol before marker done");
    a_data_answer: assert property (I_SOP_DONE && O_BUSY && !mark_r |-> ##[2:4] O_SYM_VALID)
        else $error("no data symbol after marker");
    a_done_pulse: assert property (O_RX_DONE |=> !O_RX_DONE)
        else $error("frame end longer than one cycle");
    a_ack_starts: assert property (O_RX_DONE && O_RX_CRC_OK && I_AUTO_ACK && !O_BUSY |-> ##[1:8] O_BUSY)
        else $error("no acknowledge after good frame");
endmodule

// >>> testbench/rdmsc_modulator.sv
`timescale 1ns/1ps
module rdmsc_modulator (
    input  wire logic I_CLK,   // Clock
    input  wire logic I_RSTN,  // Sync reset, active low
    input  wire logic i_slow,  // Accept one cycle in four
    input  wire logic i_valid, // Symbol offered
    output logic      o_ready, // Symbol accepted
    output logic [15:0] o_count  // Symbols accepted
);
    logic [1:0] cnt_r;
    assign o_ready = !i_slow || cnt_r == 2'h0;
    always_ff @(posedge I_CLK)
    begin
        if (!I_RSTN)
        begin
            cnt_r   <= 2'h0;
            o_count <= 16'h0000;
        end
        else
        begin
            cnt_r <= cnt_r + 2'h1;
            if (i_valid && o_ready) o_count <= o_count + 16'h0001;
        end
    end
endmodule

// >>> testbench/rdmsc_bench.sv
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin failures++; $display("ERROR t=%0t got=%h exp=%h", $time, (a), (e)); end end
module rdmsc_bench;
    typedef struct packed {
        logic [1:0] mode;
        logic       sh;
        logic [7:0] data;
        logic [7:0] n;
    } rdmsc_row_t;
    logic clk, rstn, auto_ack, tx_valid, tx_ready, sop_done, sym_valid, sym_ready, busy;
    logic rx_sym_valid, rx_last, rx_valid, rx_done, rx_crc_ok, slow, ok_v;
    logic [7:0]  rx_byte;
    logic [15:0] mod_count;
    logic [7:0]  pay [6];
    rdmsc_pkg::rdmsc_cfg_t  cfg;
    rdmsc_pkg::rdmsc_byte_t tx_byte;
    rdmsc_pkg::rdmsc_sym_t  sym, rx_sym;
    rdmsc_pkg::rdmsc_sym_t  expq[$], got[$];
    logic [7:0] rxq[$];
    int failures, comparisons, done_n, total;
    rdmsc_row_t rows [8] = '{
        '{2'h0, 1'b0, 8'hB4, 8'h18}, '{2'h0, 1'b1, 8'h01, 8'h18},
        '{2'h1, 1'b0, 8'h5A, 8'h03}, '{2'h1, 1'b1, 8'hFF, 8'h03},
        '{2'h2, 1'b0, 8'h96, 8'h0C}, '{2'h2, 1'b1, 8'h00, 8'h0C},
        '{2'h3, 1'b0, 8'hC6, 8'h18}, '{2'h3, 1'b1, 8'h80, 8'h18}};
    rdmsc_top rdmsc_top_inst (.I_CLK(clk), .I_RSTN(rstn), .I_CFG(cfg), .I_AUTO_ACK(auto_ack),
        .I_TX_BYTE(tx_byte), .I_TX_VALID(tx_valid), .O_TX_READY(tx_ready),
        .I_SOP_DONE(sop_done), .O_SYM_VALID(sym_valid), .O_SYM(sym), .I_SYM_READY(sym_ready),
        .O_BUSY(busy), .I_RX_SYM_VALID(rx_sym_valid), .I_RX_SYM(rx_sym), .I_RX_LAST(rx_last),
        .O_RX_VALID(rx_valid), .O_RX_BYTE(rx_byte), .O_RX_DONE(rx_done), .O_RX_CRC_OK(rx_crc_ok));
    rdmsc_modulator rdmsc_modulator_inst (.I_CLK(clk), .I_RSTN(rstn), .i_slow(slow),
        .i_valid(sym_valid), .o_ready(sym_ready), .o_count(mod_count));
    // Sampled mid-cycle: values that the next rising edge sees
    always @(negedge clk)
    begin
        if (sym_valid && sym_ready) got.push_back(sym);
        if (rx_valid) rxq.push_back(rx_byte);
        if (rx_done) ok_v = rx_crc_ok;
        if (rx_done) done_n++;
    end
    task automatic tick(input int k);
        repeat (k) @(negedge clk);
    endtask
    function automatic logic [15:0] crc16(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {b, 8'h00};
        for (int i = 0; i < 8; i++) r = {r[14:0], 1'b0} ^ (r[15] ? rdmsc_pkg::CRC_POLY : 16'h0000);
        return r;
    endfunction
    task automatic add_byte(input rdmsc_pkg::rdmsc_cfg_t c, input logic [7:0] b, input logic k);
        rdmsc_pkg::rdmsc_sym_t s;
        int w;
        w = c.mode == rdmsc_pkg::RDMSC_MODE_BYTE ? 8 : (c.mode == rdmsc_pkg::RDMSC_MODE_TWO ? 2 : 1);
        for (int i = 8 - w; i >= 0; i -= w)
        begin
            s = '{c.mode == rdmsc_pkg::RDMSC_MODE_GFSK, (b >> i) & ((8'h1 << w) - 8'h1), c.short_code, k};
            expq.push_back(s);
        end
    endtask
    task automatic push(input logic [7:0] b, input logic l);
        logic r;
        tx_byte  = '{b, l};
        tx_valid = 1'b1;
        for (int k = 0; k < 4000; k++)
        begin
            r = tx_ready;
            @(negedge clk);
            if (r) break;
        end
        tx_valid = 1'b0;
        tx_byte  = ~tx_byte;
        tick(1);
    endtask
    task automatic marker;
        for (int k = 0; k < 100 && busy !== 1'b1; k++) tick(1);
        sop_done = 1'b1;
        tick(1);
        sop_done = 1'b0;
    endtask
    task automatic check_syms(input int ns);
        for (int k = 0; k < 20000 && got.size() < ns; k++) tick(1);
        tick(4);
        total += ns;
        `CHK(got.size(), ns)
        foreach (expq[i]) `CHK(got[i], expq[i])
        for (int k = 0; k < 400 && busy !== 1'b0; k++) tick(1);
        `CHK(busy, 1'b0)
        expq.delete();
        got.delete();
    endtask
    task automatic send_pkt(input rdmsc_pkg::rdmsc_cfg_t c, input int n, input int ns);
        logic [15:0] cr;
        cr  = rdmsc_pkg::CRC_INIT;
        cfg = c;
        for (int i = 0; i < n; i++)
        begin
            add_byte(c, pay[i], 1'b0);
            cr = crc16(cr, pay[i]);
        end
        add_byte(c, cr[15:8], 1'b1);
        add_byte(c, cr[7:0], 1'b1);
        for (int i = 0; i < n && i < 4; i++) push(pay[i], i == n - 1);
        if (n > 4) `CHK(tx_ready, 1'b0)
        marker();
        // Setting changed mid-packet must not reach the symbols
        cfg = '{rdmsc_pkg::rdmsc_mode_t'(c.mode + 2'h1), !c.short_code};
        for (int i = 4; i < n; i++) push(pay[i], i == n - 1);
        check_syms(ns);
    endtask
    task automatic rx_frame(input rdmsc_pkg::rdmsc_sym_t t, input int n, input logic bad);
        logic [15:0] cr;
        logic [7:0]  b;
        int          d0;
        int          w;
        cr = rdmsc_pkg::CRC_INIT;
        d0 = done_n;
        w  = t.gfsk ? 1 : (t.short_code ? 2 : 8);
        rxq.delete();
        for (int i = 0; i < n; i++) cr = crc16(cr, pay[i]);
        cr[0] = cr[0] ^ bad;
        for (int j = 0; j < n + 2; j++)
        begin
            b = j < n ? pay[j] : (j == n ? cr[15:8] : cr[7:0]);
            for (int i = 8 - w; i >= 0; i -= w)
            begin
                rx_sym = '{t.gfsk, (b >> i) & ((8'h1 << w) - 8'h1), t.short_code, j >= n};
                rx_sym_valid = 1'b1;
                tick(1);
                rx_sym_valid = 1'b0;
                rx_sym = ~rx_sym;
                tick(1);
            end
        end
        rx_last = 1'b1;
        tick(1);
        rx_last = 1'b0;
        for (int k = 0; k < 100 && done_n == d0; k++) tick(1);
        `CHK(done_n, d0 + 1)
        `CHK(ok_v, !bad)
        for (int i = 0; i < n; i++) `CHK(rxq[i], pay[i])
    endtask
    task automatic tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial
    begin
        #200000;
        failures++;
        tally_and_finish();
    end
    initial
    begin
        {rstn, auto_ack, tx_valid, sop_done, slow, rx_sym_valid, rx_last} = 7'h00;
        cfg     = '0;
        tx_byte = '0;
        rx_sym  = '0;
        tick(20);
        `CHK(tx_ready, 1'b1)
        `CHK({busy, sym_valid, rx_valid, rx_done}, 4'h0)
        rstn = 1'b1;
        tick(2);
        foreach (rows[r])
        begin
            pay[0] = rows[r].data;
            slow   = rows[r].sh;
            send_pkt('{rdmsc_pkg::rdmsc_mode_t'(rows[r].mode), rows[r].sh}, 1, rows[r].n);
        end
        slow = 1'b1;
        pay  = '{8'h00, 8'hFF, 8'h3C, 8'hC3, 8'h81, 8'h7E};
        send_pkt('{rdmsc_pkg::RDMSC_MODE_BYTE, 1'b1}, 6, 8);
        slow = 1'b0;
        // Reset in mid-run while a packet waits for its marker
        push(8'h11, 1'b1);
        for (int k = 0; k < 100 && busy !== 1'b1; k++) tick(1);
        `CHK(mod_count, 16'(total))
        rstn = 1'b0;
        tick(2);
        `CHK({busy, sym_valid, tx_ready}, 3'h1)
        rstn  = 1'b1;
        total = 0;
        tick(2);
        `CHK({busy, sym_valid, tx_ready}, 3'h1)
        rx_frame('{1'b0, 8'h00, 1'b0, 1'b0}, 2, 1'b0);
        rx_frame('{1'b0, 8'h00, 1'b1, 1'b0}, 2, 1'b0);
        rx_frame('{1'b1, 8'h00, 1'b0, 1'b0}, 2, 1'b0);
        rx_frame('{1'b0, 8'h00, 1'b0, 1'b0}, 2, 1'b1);
        auto_ack = 1'b1;
        cfg      = '{rdmsc_pkg::RDMSC_MODE_TWO, 1'b0};
        add_byte(cfg, rdmsc_pkg::ACK_BYTE, 1'b0);
        rx_frame('{1'b0, 8'h00, 1'b0, 1'b0}, 2, 1'b0);
        marker();
        check_syms(4);
        rx_frame('{1'b0, 8'h00, 1'b0, 1'b0}, 2, 1'b1);
        tick(20);
        `CHK(busy, 1'b0)
        `CHK(mod_count, 16'(total))
        tally_and_finish();
    end
endmodule
bind rdmsc_top rdmsc_assertions rdmsc_assertions_inst (.I_CLK(I_CLK), .I_RSTN(I_RSTN),
    .I_CFG(I_CFG), .I_AUTO_ACK(I_AUTO_ACK), .I_SOP_DONE(I_SOP_DONE), .O_SYM_VALID(O_SYM_VALID),
    .O_SYM(O_SYM), .I_SYM_READY(I_SYM_READY), .O_BUSY(O_BUSY), .O_RX_DONE(O_RX_DONE),
    .O_RX_CRC_OK(O_RX_CRC_OK));
